// ---- adc_port_checker.sv ----
// Checker for the converter serial port: watches top-level pins only.
// Assumes one clock domain on mclk with asynchronous active-high rst.
`timescale 1ns/1ns
`default_nettype none

module adc_port_checker #(
	parameter [7:0] BIT_HALF = 8'h08
)(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Configuration pins
	input wire logic resetPinN,
	input wire logic masterSelectPin,
	// Serial pins driven by the block
	input wire logic bitClkOut,
	input wire logic bitClkOe,
	input wire logic wordSelectClkOut,
	input wire logic wordSelectClkOe,
	input wire logic frameSyncOut,
	input wire logic frameSyncOe,
	input wire logic serialOut,
	// Status
	input wire logic calBusy,
	input wire logic commonVoltageSel
);
	// Length of the current driven high phase of the bit clock
	logic [7:0] hiCnt;

	// Counter restarts whenever the clock is low or undriven
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			hiCnt <= 8'h00;
		end else begin
			hiCnt <= (bitClkOut && bitClkOe) ? hiCnt + 8'h01 : 8'h00;
		end
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	AST_CAL_RISE: assert property ($fell(resetPinN) |-> ##[1:5] calBusy)
		else $error("busy flag late after reset pin fall");
	AST_DOWN_QUIET: assert property ((!resetPinN)[*4] |-> !bitClkOe && !serialOut)
		else $error("pins active while powered down");
	AST_DOWN_BUSY: assert property ((!resetPinN)[*4] |-> calBusy)
		else $error("busy flag low while powered down");
	AST_SLAVE_QUIET: assert property ((!masterSelectPin)[*4] |->
		!wordSelectClkOe && !frameSyncOe && !bitClkOe)
		else $error("clock pins driven in a slave format");
	// Pin-level disable: a reset pin fall may cut a phase short
	AST_SER_FALL: assert property (disable iff (rst || !resetPinN)
		bitClkOe && $past(bitClkOe) && $changed(serialOut) |-> $fell(bitClkOut))
		else $error("serial data moved off a bit clock fall");
	AST_WS_FALL: assert property (disable iff (rst || !resetPinN)
		wordSelectClkOe && $past(wordSelectClkOe) && $changed(wordSelectClkOut)
		|-> $fell(bitClkOut))
		else $error("word select moved off a bit clock fall");
	AST_BCK_HALF: assert property (disable iff (rst || !resetPinN)
		$fell(bitClkOut) && $past(bitClkOe) |-> hiCnt == BIT_HALF)
		else $error("bit clock high phase has wrong length");
	AST_FS_WS: assert property (disable iff (rst || !resetPinN)
		$changed(wordSelectClkOut) && wordSelectClkOe && $past(wordSelectClkOe)
		|-> ##16 $rose(frameSyncOut))
		else $error("frame sync not one bit after word select");
	AST_CV_IN_CAL: assert property (commonVoltageSel |-> calBusy)
		else $error("common voltage selected outside calibration");

	// Main scenarios reached
	cover property ($fell(calBusy));
	cover property ($rose(frameSyncOut));
	cover property (serialOut && !bitClkOe);
endmodule // adc_port_checker

bind adc_serial_port adc_port_checker #(.BIT_HALF(BIT_HALF)) chk (.mclk(mclk), .rst(rst),
	.resetPinN(resetPinN), .masterSelectPin(masterSelectPin), .bitClkOut(bitClkOut),
	.bitClkOe(bitClkOe), .wordSelectClkOut(wordSelectClkOut),
	.wordSelectClkOe(wordSelectClkOe), .frameSyncOut(frameSyncOut),
	.frameSyncOe(frameSyncOe), .serialOut(serialOut), .calBusy(calBusy),
	.commonVoltageSel(commonVoltageSel));

`default_nettype wire

// ---- adc_port_regs.vh ----
// Constants for the stereo converter serial port and offset calibration.
// Assumes a 100 MHz system clock; included by bare name, definitions only.
`ifndef ADC_PORT_REGS_VH
`define ADC_PORT_REGS_VH

// System clock period and the pin-fall to busy-rise limit
`define MCLK_PERIOD_NS 10
`define CAL_RISE_NS 50
`define CAL_RISE_CYCLES (`CAL_RISE_NS / `MCLK_PERIOD_NS)

// Word-select rising edges after release, master mode
`define CAL_END_NORMAL 15'h2200
`define CAL_END_DOUBLE 15'h4400
`define DATA_VALID_NORMAL 15'h2300
`define DATA_VALID_DOUBLE 15'h4600

// Bit clocks per channel slot (128fs and 64fs per frame)
`define SLOT_BITS_NORMAL 7'h40
`define SLOT_BITS_DOUBLE 7'h20

// Sample layout
`define SAMPLE_BITS 24
`define RAW_WIDTH 26
`define SHIFT_BITS 64

// Master bit clock half period in system clocks (160 ns bit clock)
`define BIT_HALF_CYCLES 8'h08

// DC filter shift: fc = fs / (2*pi*2^13), about 1 Hz at 48 kHz
`define HPF_SHIFT 13

// Word-select period jitter allowed before a resync, in system clocks
`define RESYNC_TOL_CYCLES 20'h0_0040
`define PERIOD_LIMIT 20'hF_FFFF

`endif

// ---- adc_serial_port.v ----
// Digital output side of a two-channel 24-bit converter: serial port and calibration.
// Assumes decimated raw samples arrive on mclk; all pins are asynchronous and synchronised.
// Function
// - Two mode pins pick one of four formats
// - Samples shift out MSB first, two's complement
// - Lost word-select sync restarts calibration automatically
// - Master drives bit clock, 2fs frame sync
// - Serial data changes on bit-clock falling edges
// - Left-justified slave MSB follows word-select edge directly
// - Slave frame sync on falls; ignored in I2S
// - Reset low powers down; release starts calibration
// - Busy output high in calibration, rises quickly
// - Calibration ends 8704 or 17408 edges after release
// - Data valid 8960 or 17920 edges after release
// - Slave counts one word-select period longer
// - Per-channel offset stored, subtracted from samples
// - Source pin picks analog inputs or common voltage
// - DC high-pass, 1 Hz at 48 kHz
// - Outputs saturate at full-scale codes
`timescale 1ns/1ns
`default_nettype none
`include "adc_port_regs.vh"

module adc_serial_port #(
	parameter RAW_W = `RAW_WIDTH,
	parameter [7:0] BIT_HALF = `BIT_HALF_CYCLES,
	parameter [14:0] CAL_END_NORMAL = `CAL_END_NORMAL,
	parameter [14:0] CAL_END_DOUBLE = `CAL_END_DOUBLE,
	parameter [14:0] DATA_VALID_NORMAL = `DATA_VALID_NORMAL,
	parameter [14:0] DATA_VALID_DOUBLE = `DATA_VALID_DOUBLE,
	parameter HPF_SHIFT = `HPF_SHIFT
)(
	// Clock and reset
	input wire mclk,
	input wire rst,
	// Configuration pins
	input wire resetPinN,
	input wire masterSelectPin,
	input wire i2sFormatPin,
	input wire doubleRateSelect,
	input wire calSourceSelect,
	// Raw samples from the decimator
	input wire [RAW_W-1:0] rawLeft,
	input wire [RAW_W-1:0] rawRight,
	input wire rawValid,
	// Bit clock pin
	input wire bitClkIn,
	output reg bitClkOut,
	output reg bitClkOe,
	// Word-select clock pin
	input wire wordSelectClkIn,
	output reg wordSelectClkOut,
	output reg wordSelectClkOe,
	// Frame-sync pin
	input wire frameSyncIn,
	output reg frameSyncOut,
	output reg frameSyncOe,
	// Serial data and status
	output reg serialOut,
	output reg calBusy,
	output reg commonVoltageSel
);

	localparam SB = `SAMPLE_BITS;
	localparam SW = `SHIFT_BITS;

	// Calibration states
	localparam [3:0] S_DOWN = 4'h1;
	localparam [3:0] S_CAL = 4'h2;
	localparam [3:0] S_WAIT = 4'h4;
	localparam [3:0] S_RUN = 4'h8;

	// Two-stage synchronisers for every pin; only stage B is read
	reg [7:0] syncA;
	reg [7:0] syncB;
	wire pinOn = syncB[7];
	wire isMaster = syncB[6];
	wire isI2s = syncB[5];
	wire isDouble = syncB[4];
	wire calSrc = syncB[3];
	wire sBit = syncB[2];
	wire sWs = syncB[1];
	wire sFs = syncB[0];

	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			syncA <= 8'h00;
			syncB <= 8'h00;
		end else begin
			syncA <= {resetPinN, masterSelectPin, i2sFormatPin, doubleRateSelect,
				calSourceSelect, bitClkIn, wordSelectClkIn, frameSyncIn};
			syncB <= syncA;
		end
	end

	// Previous slave clock levels for edge finding
	reg prevBit;
	reg prevWs;
	reg [2:0] prevMode; // Format pins last cycle, to spot a change

	// Master clock generator state
	reg [7:0] divCount;
	reg [6:0] bitCount; // Bit position within the frame

	// Slot length follows the rate pin
	wire [6:0] slotBits = isDouble ? `SLOT_BITS_DOUBLE : `SLOT_BITS_NORMAL;
	wire [6:0] frameLast = {slotBits[5:0], 1'b0} - 7'h01;
	wire mTick = (divCount == BIT_HALF - 8'h01);
	wire mFall = isMaster && mTick && bitClkOut;
	wire [6:0] nextBit = (bitCount >= frameLast) ? 7'h00 : bitCount + 7'h01;
	wire nextRight = (nextBit >= slotBits);
	wire [6:0] nextPos = nextRight ? nextBit - slotBits : nextBit;
	// Left slot has word select high, or low in I2S
	wire nextWsM = nextRight ? isI2s : ~isI2s;

	// Unified events for both master and slave
	wire fallEv = isMaster ? mFall : (prevBit & ~sBit);
	wire wsEdgeM = mFall && (nextPos == 7'h00);
	wire wsEdgeS = ~isMaster && (sWs ^ prevWs);
	wire wsEdgeEv = wsEdgeM | wsEdgeS;
	wire wsNew = isMaster ? nextWsM : sWs;
	wire leftNow = wsNew ^ isI2s;
	wire wsRiseEv = wsEdgeEv & wsNew;
	// Left-justified slave shifts only while frame sync is high
	wire shiftGate = isMaster | isI2s | sFs;

	// Master bit clock, word select and frame sync
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			divCount <= 8'h00;
			bitCount <= 7'h00;
			bitClkOut <= 1'b0;
			wordSelectClkOut <= 1'b0;
			frameSyncOut <= 1'b0;
		end else if (!isMaster || !pinOn) begin
			divCount <= 8'h00;
			bitCount <= frameLast;
			bitClkOut <= 1'b0;
			wordSelectClkOut <= isI2s;
			frameSyncOut <= 1'b0;
		end else if (mTick) begin
			divCount <= 8'h00;
			bitClkOut <= ~bitClkOut;
			if (bitClkOut) begin
				bitCount <= nextBit;
				wordSelectClkOut <= nextWsM;
				// 2fs, half a slot high, rising one bit after the edge
				frameSyncOut <= (nextPos >= 7'h01) && (nextPos <= {1'b0, slotBits[6:1]});
			end
		end else begin
			divCount <= divCount + 8'h01;
		end
	end

	// Pin drivers are enabled only in master formats
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			bitClkOe <= 1'b0;
			wordSelectClkOe <= 1'b0;
			frameSyncOe <= 1'b0;
			prevBit <= 1'b0;
			prevWs <= 1'b0;
			prevMode <= 3'h0;
		end else begin
			bitClkOe <= isMaster & pinOn;
			wordSelectClkOe <= isMaster & pinOn;
			frameSyncOe <= isMaster & pinOn;
			prevBit <= sBit;
			prevWs <= sWs;
			prevMode <= {isMaster, isI2s, isDouble};
		end
	end

	// Word-select period watch: a jump in period or a stall means lost sync
	reg [19:0] periodCount;
	reg [19:0] lastPeriod;
	reg havePrevRise; // First rise after power-up closes only a partial period
	wire [19:0] periodDiff = (periodCount > lastPeriod) ? periodCount - lastPeriod
		: lastPeriod - periodCount;
	wire periodJump = wsRiseEv && (lastPeriod != 20'h0_0000)
		&& (periodDiff > `RESYNC_TOL_CYCLES);
	wire periodStall = (periodCount == `PERIOD_LIMIT);
	wire modeChange = (prevMode != {isMaster, isI2s, isDouble});
	wire syncLost = ((~isMaster & (periodJump | periodStall)) | modeChange);

	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			periodCount <= 20'h0_0000;
			lastPeriod <= 20'h0_0000;
			havePrevRise <= 1'b0;
		end else if (!pinOn) begin
			periodCount <= 20'h0_0000;
			lastPeriod <= 20'h0_0000;
			havePrevRise <= 1'b0;
		end else if (syncLost) begin
			periodCount <= 20'h0_0000;
			lastPeriod <= 20'h0_0000;
		end else if (wsRiseEv) begin
			periodCount <= 20'h0_0000;
			// A partial first period would look like a jump, so it is not kept
			lastPeriod <= havePrevRise ? periodCount : 20'h0_0000;
			havePrevRise <= 1'b1;
		end else begin
			periodCount <= periodCount + 20'h0_0001;
		end
	end

	// Calibration sequencing by counting word-select rising edges
	reg [3:0] state;
	reg [3:0] nextState;
	reg [14:0] edgeCount;
	wire [14:0] slaveExtra = isMaster ? 15'h0000 : 15'h0001;
	wire [14:0] calTarget = (isDouble ? CAL_END_DOUBLE : CAL_END_NORMAL) + slaveExtra;
	wire [14:0] validTarget = (isDouble ? DATA_VALID_DOUBLE : DATA_VALID_NORMAL)
		+ slaveExtra;
	wire [14:0] edgeNext = edgeCount + 15'h0001;

	always @* begin
		nextState = state;
		case (state)
			S_DOWN: begin
				if (pinOn) begin
					nextState = S_CAL;
				end
			end
			S_CAL: begin
				if (wsRiseEv && edgeNext == calTarget) begin
					nextState = S_WAIT;
				end
			end
			S_WAIT: begin
				if (wsRiseEv && edgeNext == validTarget) begin
					nextState = S_RUN;
				end
			end
			S_RUN: begin
				nextState = S_RUN;
			end
			default: begin
				nextState = S_DOWN;
			end
		endcase
		if (!pinOn) begin
			nextState = S_DOWN;
		end else if (syncLost && state != S_DOWN) begin
			nextState = S_CAL;
		end
	end

	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			state <= S_DOWN;
			edgeCount <= 15'h0000;
			calBusy <= 1'b1;
			commonVoltageSel <= 1'b0;
		end else begin
			state <= nextState;
			if (nextState == S_DOWN || (nextState == S_CAL && state != S_CAL)) begin
				edgeCount <= 15'h0000;
			end else if (wsRiseEv) begin
				edgeCount <= edgeNext;
			end
			// Read straight off the synchronised pin to keep the rise short
			calBusy <= ~pinOn | (nextState == S_CAL);
			commonVoltageSel <= (nextState == S_CAL) & ~calSrc;
		end
	end

	// Sample pipeline: latch, read offsets, subtract, filter
	reg [2:0] step;
	reg [RAW_W-1:0] holdLeft;
	reg [RAW_W-1:0] holdRight;
	wire inCal = (state == S_CAL);
	wire [RAW_W-1:0] offsetWord;
	wire [SB-1:0] outLeft;
	wire [SB-1:0] outRight;

	// Offset-corrected difference, one bit wider so it cannot wrap
	function [RAW_W:0] subOffset;
		input [RAW_W-1:0] a;
		input [RAW_W-1:0] b;
		begin
			subOffset = {a[RAW_W-1], a} - {b[RAW_W-1], b};
		end
	endfunction

	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			step <= 3'h0;
			holdLeft <= {RAW_W{1'b0}};
			holdRight <= {RAW_W{1'b0}};
		end else begin
			step <= {step[1:0], rawValid & pinOn};
			if (rawValid) begin
				holdLeft <= rawLeft;
				holdRight <= rawRight;
			end
		end
	end

	// During calibration every sample overwrites the stored offsets
	offset_store #(
		.W(RAW_W),
		.DEPTH(2),
		.AW(1)
	) offsets (
		.clk(mclk),
		.rst(rst),
		.we(inCal & (step[0] | step[1])),
		.waddr(step[1]),
		.wdata(step[0] ? holdLeft : holdRight),
		.raddr(step[1]),
		.rdata(offsetWord)
	);

	dc_highpass #(
		.IN_W(RAW_W + 1),
		.SHIFT(HPF_SHIFT),
		.OUT_W(SB)
	) hpfLeft (
		.clk(mclk),
		.rst(rst),
		.en(step[1]),
		.clr(inCal | ~pinOn),
		.x(subOffset(holdLeft, offsetWord)),
		.y(outLeft)
	);

	dc_highpass #(
		.IN_W(RAW_W + 1),
		.SHIFT(HPF_SHIFT),
		.OUT_W(SB)
	) hpfRight (
		.clk(mclk),
		.rst(rst),
		.en(step[2]),
		.clr(inCal | ~pinOn),
		.x(subOffset(holdRight, offsetWord)),
		.y(outRight)
	);

	// Slot word: sample first then zeros; I2S puts one idle bit before the MSB
	wire [SB-1:0] slotSample = (state == S_RUN) ? (leftNow ? outLeft : outRight) : {SB{1'b0}};
	wire [SW-1:0] loadWord = isI2s ? {1'b0, slotSample, {(SW-SB-1){1'b0}}}
		: {slotSample, {(SW-SB){1'b0}}};
	reg [SW-1:0] shiftReg;

	// Shifter: load on the word-select edge, then advance on each falling bit clock that shiftGate lets through
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			shiftReg <= {SW{1'b0}};
			serialOut <= 1'b0;
		end else if (!pinOn) begin
			shiftReg <= {SW{1'b0}};
			serialOut <= 1'b0;
		end else if (wsEdgeEv) begin
			shiftReg <= loadWord;
			serialOut <= loadWord[SW-1];
		end else if (fallEv && shiftGate) begin
			shiftReg <= {shiftReg[SW-2:0], 1'b0};
			serialOut <= shiftReg[SW-2];
		end
	end

endmodule // adc_serial_port
`default_nettype wire

// ---- audio_receiver.sv ----
// Far-end receiver model: free-running slave clocks and slot capture.
// Assumes the bench resolves every pin and that all sampling is on mclk.
`timescale 1ns/1ns
`default_nettype none

module audio_receiver (
	// Clock and format
	input wire logic mclk,
	input wire logic i2s,
	input wire logic dbl,
	// Resolved pins
	input wire logic bck,
	input wire logic ws,
	input wire logic sdo,
	// Clocks offered in slave formats
	output var logic bckDrv,
	output var logic wsDrv,
	output var logic fsDrv,
	// Received words and stray tail bits
	output var logic [23:0] wordL,
	output var logic [23:0] wordR,
	output var int tailErrs
);
	int div, gb, nb, rx;
	logic pb, pw;
	logic [23:0] cur;

	initial begin
		{bckDrv, wsDrv, fsDrv, pb, pw} = 5'h00;
		{wordL, wordR, cur} = 72'h0;
		div = 0;
		gb = 0;
		rx = 0;
		tailErrs = 0;
	end

	// Clocks never stop, so a 160 ns bit clock locked to mclk
	always @(posedge mclk) begin
		div <= (div + 1) % 8;
		if (div == 7) begin
			bckDrv <= !bckDrv;
			if (bckDrv) begin
				nb = (gb + 1) % (dbl ? 32 : 64);
				gb <= nb;
				// Word select moves with the bit clock fall, never its rise
				if (nb == 0) begin
					wsDrv <= !wsDrv;
				end
				fsDrv <= nb >= 1 && nb <= (dbl ? 16 : 32);
			end
		end
	end

	// Bits taken on bit clock rises; a word select edge closes the slot
	always @(posedge mclk) begin
		pb <= bck;
		pw <= ws;
		if (ws != pw) begin
			if (pw ^ i2s) begin
				wordL <= cur;
			end else begin
				wordR <= cur;
			end
			cur <= 24'h00_0000;
			rx <= 0;
		end else if (bck && !pb) begin
			// I2S delays the first bit by one period
			if (rx >= i2s && rx < 24 + i2s) begin
				cur <= {cur[22:0], sdo};
			end else begin
				tailErrs <= tailErrs + (sdo ? 1 : 0);
			end
			rx <= rx + 1;
		end
	end
endmodule // audio_receiver

`default_nettype wire

// ---- dc_highpass.v ----
// First-order DC-removal filter for one channel with 24-bit saturating output.
// Assumes one input sample per en pulse; clr empties the filter state.
`timescale 1ns/1ns
`default_nettype none

module dc_highpass #(
	parameter IN_W = 27,
	parameter SHIFT = 13,
	parameter OUT_W = 24
)(
	// Clock and reset
	input wire clk,
	input wire rst,
	// Sample in
	input wire en,
	input wire clr,
	input wire [IN_W-1:0] x,
	// Filtered sample out
	output reg [OUT_W-1:0] y
);

	localparam ACC_W = IN_W + SHIFT + 1;

	// Accumulator holds the running DC estimate scaled by 2^SHIFT
	reg [ACC_W-1:0] acc;
	wire [ACC_W-1:0] xExt = {{(SHIFT+1){x[IN_W-1]}}, x};
	wire [ACC_W-1:0] dcEst = $signed(acc) >>> SHIFT;
	wire [ACC_W-1:0] diff = xExt - dcEst;

	// Clamp to full scale: top bits must all equal the sign to fit
	function [OUT_W-1:0] clampOut;
		input [ACC_W-1:0] v;
		begin
			if (&v[ACC_W-1:OUT_W-1] || ~|v[ACC_W-1:OUT_W-1]) begin
				clampOut = v[OUT_W-1:0];
			end else if (v[ACC_W-1]) begin
				clampOut = {1'b1, {(OUT_W-1){1'b0}}};
			end else begin
				clampOut = {1'b0, {(OUT_W-1){1'b1}}};
			end
		end
	endfunction

	// Cut-off scales with fs because the filter steps once per sample
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			acc <= {ACC_W{1'b0}};
			y <= {OUT_W{1'b0}};
		end else if (clr) begin
			acc <= {ACC_W{1'b0}};
			y <= {OUT_W{1'b0}};
		end else if (en) begin
			acc <= acc + diff;
			y <= clampOut(diff);
		end
	end

endmodule // dc_highpass
`default_nettype wire

// ---- offset_store.v ----
// Small offset memory: one stored calibration word per channel.
// Assumes one write port and one read port on the same clock; read data registered.
`timescale 1ns/1ns
`default_nettype none

module offset_store #(
	parameter W = 26,
	parameter DEPTH = 2,
	parameter AW = 1
)(
	// Clock and reset
	input wire clk,
	input wire rst,
	// Write port
	input wire we,
	input wire [AW-1:0] waddr,
	input wire [W-1:0] wdata,
	// Read port
	input wire [AW-1:0] raddr,
	output reg [W-1:0] rdata
);

	// Storage array; contents only matter after a calibration has written them
	reg [W-1:0] mem [0:DEPTH-1];

	// Write on request
	always @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// Registered read, cleared by reset so no unknown leaks out
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata <= {W{1'b0}};
		end else begin
			rdata <= mem[raddr];
		end
	end

endmodule // offset_store
`default_nettype wire

// ---- test_stereo_adc_serial_port_and_offset_cal.sv ----
// Bench: four serial formats, calibration counts, offset removal and clamping.
// Assumes the receiver model on the far side and shortened calibration counts.
`timescale 1ns/1ns
`default_nettype none

module test_stereo_adc_serial_port_and_offset_cal;
	// Short counts keep the run brief; calibration still ends before data valid
	localparam [14:0] CE_N = 15'h0002;
	localparam [14:0] CE_D = 15'h0003;
	localparam [14:0] DV_N = 15'h0003;
	localparam [14:0] DV_D = 15'h0005;
	logic mclk, rst, resetPinN, masterSelectPin, i2sFormatPin, doubleRateSelect;
	logic calSourceSelect, rawValid, wsPrev, oePrev;
	logic [25:0] rawLeft, rawRight;
	wire bitClkOut, bitClkOe, wordSelectClkOut, wordSelectClkOe, frameSyncOut;
	wire frameSyncOe, serialOut, calBusy, commonVoltageSel, bckDrv, wsDrv, fsDrv;
	wire [23:0] wordL, wordR;
	// Whoever enables its driver owns the pin
	wire bckPin = bitClkOe ? bitClkOut : bckDrv;
	wire wsPin = wordSelectClkOe ? wordSelectClkOut : wsDrv;
	wire fsPin = frameSyncOe ? frameSyncOut : fsDrv;
	int n_fail, checks_done, rvCnt, wsRises, tailErrs, f;

	adc_serial_port #(.CAL_END_NORMAL(CE_N), .CAL_END_DOUBLE(CE_D),
		.DATA_VALID_NORMAL(DV_N), .DATA_VALID_DOUBLE(DV_D)) uut (.mclk(mclk), .rst(rst),
		.resetPinN(resetPinN), .masterSelectPin(masterSelectPin), .i2sFormatPin(i2sFormatPin),
		.doubleRateSelect(doubleRateSelect), .calSourceSelect(calSourceSelect),
		.rawLeft(rawLeft), .rawRight(rawRight), .rawValid(rawValid), .bitClkIn(bckPin),
		.bitClkOut(bitClkOut), .bitClkOe(bitClkOe), .wordSelectClkIn(wsPin),
		.wordSelectClkOut(wordSelectClkOut), .wordSelectClkOe(wordSelectClkOe),
		.frameSyncIn(fsPin), .frameSyncOut(frameSyncOut), .frameSyncOe(frameSyncOe),
		.serialOut(serialOut), .calBusy(calBusy), .commonVoltageSel(commonVoltageSel));
	audio_receiver rx (.mclk(mclk), .i2s(i2sFormatPin), .dbl(doubleRateSelect),
		.bck(bckPin), .ws(wsPin), .sdo(serialOut), .bckDrv(bckDrv), .wsDrv(wsDrv),
		.fsDrv(fsDrv), .wordL(wordL), .wordR(wordR), .tailErrs(tailErrs));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = !mclk;
	end

	// Decimator stand-in: one sample every 256 clocks, well apart
	always @(posedge mclk) begin
		rvCnt <= (rvCnt + 1) % 256;
		rawValid <= (rvCnt == 255);
	end

	// Counts rises only from the party that owns word select
	always @(posedge mclk) begin
		wsPrev <= wsPin;
		oePrev <= wordSelectClkOe;
		if (wsPin && !wsPrev && ((wordSelectClkOe && oePrev) || !masterSelectPin)) begin
			wsRises <= wsRises + 1;
		end
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Reference output: offset already removed, clamp to 24 bits
	function automatic logic [23:0] sat24(input int v);
		if (v > 32'sh007F_FFFF) return 24'h7F_FFFF;
		if (v < -32'sh0080_0000) return 24'h80_0000;
		return v[23:0];
	endfunction

	task automatic end_sim();
		if (n_fail == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// One power-down, calibration and data phase in format fmt
	task automatic run_fmt(input int fmt);
		int offs, base, e0, n, k, ce, dv, last, xl, xr, dbl, slv;
		dbl = (fmt == 1 || fmt == 2);
		slv = !fmt[0];
		ce = (dbl ? CE_D : CE_N) + slv;
		dv = (dbl ? DV_D : DV_N) + slv;
		offs = int'($urandom % 65536) - 32768;
		@(posedge mclk);
		resetPinN <= 1'b0;
		masterSelectPin <= fmt[0];
		i2sFormatPin <= fmt[1];
		doubleRateSelect <= dbl[0];
		calSourceSelect <= $urandom % 2;
		rawLeft <= offs[25:0];
		rawRight <= offs[25:0];
		repeat (20) @(posedge mclk);
		#1 check("calBusyDown", calBusy, 1'b1);
		@(posedge mclk);
		resetPinN <= 1'b1;
		base = wsRises;
		e0 = tailErrs;
		repeat (40) @(posedge mclk);
		#1 check("cvSel", commonVoltageSel, !calSourceSelect);
		k = 0;
		while (calBusy !== 1'b0 && k < 60000) begin
			@(posedge mclk);
			k++;
		end
		repeat (2) @(posedge mclk);
		#1 check("calEndCount", wsRises - base, ce);
		// Offsets are held now, so step one channel far past full scale
		@(posedge mclk);
		rawLeft <= fmt[0] ? offs[25:0] + 26'h1F0_0000 : offs[25:0];
		rawRight <= fmt[0] ? offs[25:0] : offs[25:0] - 26'h1F0_0000;
		xl = fmt[0] ? 32'sh01F0_0000 : 0;
		xr = fmt[0] ? 0 : -32'sh01F0_0000;
		last = wsRises;
		k = 0;
		while (wsRises - base < dv + 5 && k < 30000) begin
			@(posedge mclk);
			k++;
			#1;
			if (wsRises != last) begin
				last = wsRises;
				n = last - base;
				if (n <= dv) begin
					check("wordL", wordL, 24'h00_0000);
					check("wordR", wordR, 24'h00_0000);
				end else if (n >= dv + 2) begin
					check("wordL", wordL, sat24(xl));
					check("wordR", wordR, sat24(xr));
				end
			end
		end
		check("tailBits", tailErrs - e0, 0);
	endtask

	// Watchdog: the four runs need about 60,000 clocks
	initial begin
		#900_000;
		n_fail++;
		end_sim();
	end

	initial begin
		{rst, resetPinN, masterSelectPin, i2sFormatPin} = 4'h8;
		{doubleRateSelect, calSourceSelect, rawValid, wsPrev, oePrev} = 5'h00;
		{rawLeft, rawRight} = 52'h0;
		{n_fail, checks_done, rvCnt, wsRises} = 128'h0;
		void'($urandom(86621));
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		// Formats 0..3 cover both pin levels; 1 and 2 run at double rate
		for (f = 0; f < 4; f++) begin
			run_fmt(f);
		end
		end_sim();
	end
endmodule // test_stereo_adc_serial_port_and_offset_cal

`default_nettype wire
